/* File: hw/fpg_gpio.sv */
// Four-port GPIO direction and data latch logic with an Avalon-MM register slave.
`include "fpg_cfg.svh"

module fpg_gpio (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [7:0]  e_pin_i,
  output logic      [7:0]  e_pin_o,
  output logic      [7:0]  e_pin_oe_o,
  input  wire logic [6:0]  f_pin_i,
  output logic      [6:0]  f_pin_o,
  output logic      [6:0]  f_pin_oe_o,
  input  wire logic [2:0]  g_pin_i,
  output logic      [2:0]  g_pin_o,
  output logic      [2:0]  g_pin_oe_o,
  input  wire logic [1:0]  h_pin_i,
  output logic      [1:0]  h_pin_o,
  output logic      [1:0]  h_pin_oe_o,
  input  wire logic [5:0]  timer_edge_level_select_i,
  input  wire logic [5:0]  timer_chan_out_i,
  input  wire logic [5:0]  timer_chan_oe_i,
  input  wire logic [4:0]  keypad_irq_enable_bits_i
);

  localparam int PINS = `FPG_E_W + `FPG_F_W + `FPG_G_W + `FPG_H_W;

  // Software-visible storage.
  logic [7:0]      eight_pin_latch_ff;
  logic [6:0]      seven_pin_latch_ff;
  logic [2:0]      three_pin_latch_ff;
  logic [1:0]      two_pin_latch_ff;
  logic [7:0]      eight_pin_dir_bits_ff;
  logic [6:0]      seven_pin_dir_bits_ff;
  logic [2:0]      three_pin_dir_bits_ff;
  logic [1:0]      two_pin_dir_bits_ff;
  fpg_pkg::fpg_bus_state_t bus_state_ff;
  fpg_pkg::fpg_bus_state_t nxt_bus_state;

  // Pin synchronisers: three stages, stage one is read only by stage two.
  logic [PINS-1:0] pin_s1_ff;
  logic [PINS-1:0] pin_s2_ff;
  logic [PINS-1:0] pin_s3_ff;
  logic [PINS-1:0] pin_level_ff;
  logic [PINS-1:0] pin_raw;

  // Drive pattern computed before the output flops.
  logic [PINS-1:0] nxt_pin_val;
  logic [PINS-1:0] nxt_pin_oe;
  logic [PINS-1:0] pin_val_ff;
  logic [PINS-1:0] pin_oe_ff;
  logic [PINS-1:0] all_latch;
  logic [PINS-1:0] all_dir;
  logic [PINS-1:0] periph_own;
  logic [PINS-1:0] periph_val;
  logic [PINS-1:0] periph_oe;
  logic [PINS-1:0] read_view;

  logic            wr_go;
  logic            rd_go;
  logic [31:0]     nxt_rdata;
  logic [31:0]     rdata_ff;
  logic            wait_ff;

  assign pin_raw = {h_pin_i, g_pin_i, f_pin_i, e_pin_i};
  assign all_latch = {two_pin_latch_ff, three_pin_latch_ff, seven_pin_latch_ff, eight_pin_latch_ff};
  assign all_dir = {two_pin_dir_bits_ff, three_pin_dir_bits_ff, seven_pin_dir_bits_ff, eight_pin_dir_bits_ff};

  // The synchronised level only moves when stages two and three agree, filtering one-cycle glitches.
  always_ff @(posedge mclk_i) begin
    pin_s1_ff <= pin_raw;
    pin_s2_ff <= pin_s1_ff;
    pin_s3_ff <= pin_s2_ff;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pin_level_ff <= '0;
    end else begin
      pin_level_ff <= (pin_s2_ff & pin_s3_ff) | (pin_level_ff & (pin_s2_ff | pin_s3_ff));
    end
  end

  // Map peripheral ownership onto the flat pin vector; only port F pins 0 to 5 and the keypad pins are shared here.
  always_comb begin
    periph_own = '0;
    periph_val = '0;
    periph_oe  = '0;
    periph_own[`FPG_E_W +: 6] = timer_edge_level_select_i;
    periph_val[`FPG_E_W +: 6] = timer_chan_out_i;
    periph_oe[`FPG_E_W +: 6]  = timer_chan_oe_i;
    // Keypad-enabled pins are owned with the driver held off.
    periph_own[`FPG_E_W + `FPG_F_W +: 5] = keypad_irq_enable_bits_i;
  end

  // Per-pin output buffer control.
  generate
    for (genvar i = 0; i < PINS; i++) begin : g_pin
      always_comb begin
        if (periph_own[i]) begin
          nxt_pin_val[i] = periph_val[i];
          nxt_pin_oe[i]  = periph_oe[i];
        end else begin
          nxt_pin_val[i] = all_latch[i];
          nxt_pin_oe[i]  = all_dir[i];
        end
      end
      // Direction always selects the read source, even while a peripheral owns the pin.
      assign read_view[i] = all_dir[i] ? all_latch[i] : pin_level_ff[i];
    end
  endgenerate

  // Registered pin drive; this costs one cycle after the write edge but keeps outputs glitch free.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pin_val_ff <= '0;
      pin_oe_ff  <= '0;
    end else begin
      pin_val_ff <= nxt_pin_val;
      pin_oe_ff  <= nxt_pin_oe;
    end
  end

  assign e_pin_o    = pin_val_ff[7:0];
  assign e_pin_oe_o = pin_oe_ff[7:0];
  assign f_pin_o    = pin_val_ff[14:8];
  assign f_pin_oe_o = pin_oe_ff[14:8];
  assign g_pin_o    = pin_val_ff[17:15];
  assign g_pin_oe_o = pin_oe_ff[17:15];
  assign h_pin_o    = pin_val_ff[19:18];
  assign h_pin_oe_o = pin_oe_ff[19:18];

  // Bus handshake: a request waits one cycle, then completes in the DONE state.
  always_comb begin
    case (bus_state_ff)
      fpg_pkg::FPG_IDLE: nxt_bus_state = (avs_read_i | avs_write_i) ? fpg_pkg::FPG_DONE : fpg_pkg::FPG_IDLE;
      fpg_pkg::FPG_DONE: nxt_bus_state = fpg_pkg::FPG_IDLE;
      default:           nxt_bus_state = fpg_pkg::FPG_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bus_state_ff <= fpg_pkg::FPG_IDLE;
    end else begin
      bus_state_ff <= nxt_bus_state;
    end
  end

  // Waitrequest is high by default and drops for exactly the completing cycle.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= !((bus_state_ff == fpg_pkg::FPG_IDLE) && (avs_read_i | avs_write_i));
    end
  end

  assign avs_waitrequest_o = wait_ff;
  assign wr_go = avs_write_i && (bus_state_ff == fpg_pkg::FPG_DONE);
  assign rd_go = avs_read_i && (bus_state_ff == fpg_pkg::FPG_IDLE);

  // Data latches have no reset and take any write with byte lane 0 enabled, whatever the direction.
  always_ff @(posedge mclk_i) begin
    if (wr_go && avs_byteenable_i[0]) begin
      if (avs_address_i == `FPG_E_LATCH_IDX) begin
        eight_pin_latch_ff <= avs_writedata_i[7:0];
      end else if (avs_address_i == `FPG_F_LATCH_IDX) begin
        seven_pin_latch_ff <= avs_writedata_i[6:0];
      end else if (avs_address_i == `FPG_G_LATCH_IDX) begin
        three_pin_latch_ff <= avs_writedata_i[2:0];
      end else if (avs_address_i == `FPG_H_LATCH_IDX) begin
        two_pin_latch_ff <= avs_writedata_i[1:0];
      end
    end
  end

  // Direction registers clear at reset so every pin the timer does not own starts as an input.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      eight_pin_dir_bits_ff <= `FPG_DIR_RESET;
      seven_pin_dir_bits_ff <= 7'(`FPG_DIR_RESET);
      three_pin_dir_bits_ff <= 3'(`FPG_DIR_RESET);
      two_pin_dir_bits_ff   <= 2'(`FPG_DIR_RESET);
    end else if (wr_go && avs_byteenable_i[0]) begin
      if (avs_address_i == `FPG_E_DIR_IDX) begin
        eight_pin_dir_bits_ff <= avs_writedata_i[7:0];
      end else if (avs_address_i == `FPG_F_DIR_IDX) begin
        seven_pin_dir_bits_ff <= avs_writedata_i[6:0];
      end else if (avs_address_i == `FPG_G_DIR_IDX) begin
        three_pin_dir_bits_ff <= avs_writedata_i[2:0];
      end else if (avs_address_i == `FPG_H_DIR_IDX) begin
        two_pin_dir_bits_ff <= avs_writedata_i[1:0];
      end
    end
  end

  // Read mux; unmapped addresses read zero.
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (avs_address_i == `FPG_E_LATCH_IDX) begin
      nxt_rdata[7:0] = read_view[7:0];
    end else if (avs_address_i == `FPG_F_LATCH_IDX) begin
      nxt_rdata[6:0] = read_view[14:8];
    end else if (avs_address_i == `FPG_G_LATCH_IDX) begin
      nxt_rdata[2:0] = read_view[17:15];
    end else if (avs_address_i == `FPG_H_LATCH_IDX) begin
      nxt_rdata[1:0] = read_view[19:18];
    end else if (avs_address_i == `FPG_E_DIR_IDX) begin
      nxt_rdata[7:0] = eight_pin_dir_bits_ff;
    end else if (avs_address_i == `FPG_F_DIR_IDX) begin
      nxt_rdata[6:0] = seven_pin_dir_bits_ff;
    end else if (avs_address_i == `FPG_G_DIR_IDX) begin
      nxt_rdata[2:0] = three_pin_dir_bits_ff;
    end else if (avs_address_i == `FPG_H_DIR_IDX) begin
      nxt_rdata[1:0] = two_pin_dir_bits_ff;
    end
  end

  // Read data is captured one cycle early so it stands with waitrequest low.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_go) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign avs_readdata_o = rdata_ff;

  // Cleared direction keeps the driver off one cycle later for unowned pins.
  dir_clear_hiz_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!all_dir[0] && !periph_own[0]) |=> !pin_oe_ff[0])
    else $error("pin 0 driven while input");

  dir_set_drive_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (all_dir[4] && !periph_own[4]) |=> (pin_oe_ff[4] && pin_val_ff[4] == $past(all_latch[4])))
    else $error("pin 4 not driving latch");

  reset_dir_zero_a: assert property (@(posedge mclk_i)
    rst_i |=> (all_dir == '0))
    else $error("direction not cleared by reset");

  timer_owns_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    periph_own[9] |=> (pin_oe_ff[9] == $past(timer_chan_oe_i[1])))
    else $error("timer pin follows direction");

  keypad_input_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    keypad_irq_enable_bits_i[0] |=> !g_pin_oe_o[0])
    else $error("keypad pin driven");

  // Reads are judged bit by bit, so a port with mixed directions still exercises both sources.
  read_latch_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rd_go && avs_address_i == `FPG_E_LATCH_IDX)
      |=> ((((avs_readdata_o[7:0] ^ $past(eight_pin_latch_ff)) & $past(eight_pin_dir_bits_ff)) == 8'h00)
        && !avs_waitrequest_o))
    else $error("output bit read not latch");

  read_pin_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rd_go && avs_address_i == `FPG_H_LATCH_IDX)
      |=> (((avs_readdata_o[1:0] ^ $past(pin_level_ff[19:18])) & ~$past(two_pin_dir_bits_ff)) == 2'h0))
    else $error("input bit read not pin");

  write_latch_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wr_go && avs_byteenable_i[0] && avs_address_i == `FPG_G_LATCH_IDX)
      |=> (three_pin_latch_ff == $past(avs_writedata_i[2:0])))
    else $error("latch write lost");

  dir_readback_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wr_go && avs_byteenable_i[0] && avs_address_i == `FPG_F_DIR_IDX)
      |=> (seven_pin_dir_bits_ff == $past(avs_writedata_i[6:0])))
    else $error("direction write lost");

  // The checks below cover the remaining rules and the bus timing that software relies on.
  read_h_latch_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (rd_go && avs_address_i == `FPG_H_LATCH_IDX)
      |=> (((avs_readdata_o[1:0] ^ $past(two_pin_latch_ff)) & $past(two_pin_dir_bits_ff)) == 2'h0))
    else $error("two-pin output bit read not latch");

  dir_h_write_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wr_go && avs_byteenable_i[0] && avs_address_i == `FPG_H_DIR_IDX)
      |=> (two_pin_dir_bits_ff == $past(avs_writedata_i[1:0])))
    else $error("two-pin direction write lost");

  // A pin that is neither an output nor owned by a peripheral must never see its driver on.
  input_hiz_all_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    1'b1 |=> ((pin_oe_ff & ~$past(all_dir | periph_own)) == '0))
    else $error("input pin driven");

  reset_oe_off_a: assert property (@(posedge mclk_i)
    rst_i |=> ((pin_oe_ff == '0) && avs_waitrequest_o))
    else $error("driver or bus active after reset");

  tmr_a_own_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    timer_edge_level_select_i[0]
      |=> (f_pin_oe_o[0] == $past(timer_chan_oe_i[0]) && f_pin_o[0] == $past(timer_chan_out_i[0])))
    else $error("timer A pin not taken over");

  tmr_b_own_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    timer_edge_level_select_i[5] |=> (f_pin_oe_o[5] == $past(timer_chan_oe_i[5])))
    else $error("timer B pin not taken over");

  keypad_g_all_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    1'b1 |=> ((g_pin_oe_o & $past(keypad_irq_enable_bits_i[2:0])) == 3'h0))
    else $error("keypad three-pin input driven");

  keypad_h_input_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    1'b1 |=> ((h_pin_oe_o & $past(keypad_irq_enable_bits_i[4:3])) == 2'h0))
    else $error("keypad two-pin input driven");

  // The filter must pass a level that stages two and three agree on and hold through disagreement.
  sync_agree_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    1'b1 |=> ((($past(pin_s2_ff) ~^ $past(pin_s3_ff)) & (pin_level_ff ^ $past(pin_s3_ff))) == '0))
    else $error("synchronised level missed agreed input");

  sync_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    1'b1 |=> ((($past(pin_s2_ff) ^ $past(pin_s3_ff)) & (pin_level_ff ^ $past(pin_level_ff))) == '0))
    else $error("synchronised level moved on disagreement");

  rd_ack_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_go |=> !avs_waitrequest_o)
    else $error("read not answered next cycle");

  wait_pulse_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");

endmodule

/* File: hw/fpg_cfg.svh */
// Register offsets, reset values and field widths for the four-port GPIO block.
`ifndef FPG_CFG_SVH
`define FPG_CFG_SVH
`define FPG_E_LATCH_IDX   8'h08
`define FPG_F_LATCH_IDX   8'h09
`define FPG_G_LATCH_IDX   8'h0a
`define FPG_H_LATCH_IDX   8'h0b
`define FPG_E_DIR_IDX     8'h0c
`define FPG_F_DIR_IDX     8'h0d
`define FPG_G_DIR_IDX     8'h0e
`define FPG_H_DIR_IDX     8'h0f
`define FPG_DIR_RESET     8'h00
`define FPG_E_W           8
`define FPG_F_W           7
`define FPG_G_W           3
`define FPG_H_W           2
`define FPG_TMR_A_LO      0
`define FPG_TMR_B_LO      4
`endif

/* File: hw/fpg_pkg.sv */
// Types shared by the four-port GPIO block.
package fpg_pkg;
  typedef enum logic [1:0] {
    FPG_IDLE,
    FPG_DONE
  } fpg_bus_state_t;
endpackage

/* File: bench/fpg_pin_model.sv */
// Board-side model of one GPIO port: resolves each wire from the device drive and the board level.
module fpg_pin_model #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] drv_i,
  input  wire logic [W-1:0] oe_i,
  input  wire logic [W-1:0] board_i,
  output logic      [W-1:0] lvl_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // A wire whose driver is off follows the board, so a stray drive shows as a wrong level.
  always_comb lvl_o = (oe_i & drv_i) | (~oe_i & board_i);
endmodule

/* File: bench/fpg_gpio_bench.sv */
// Self-checking bench for the four-port GPIO block.
`include "fpg_cfg.svh"
module fpg_gpio_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  avs_address_i = 8'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'h1;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [7:0]  e_pin_i, e_pin_o, e_pin_oe_o;
  logic [6:0]  f_pin_i, f_pin_o, f_pin_oe_o;
  logic [2:0]  g_pin_i, g_pin_o, g_pin_oe_o;
  logic [1:0]  h_pin_i, h_pin_o, h_pin_oe_o;
  logic [5:0]  timer_edge_level_select_i = 6'h00;
  logic [5:0]  timer_chan_out_i = 6'h00;
  logic [5:0]  timer_chan_oe_i = 6'h00;
  logic [4:0]  keypad_irq_enable_bits_i = 5'h00;
  logic [7:0]  ext [4] = '{8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  oe_w [4];
  logic [7:0]  drv_w [4];
  int          pw [4] = '{`FPG_E_W, `FPG_F_W, `FPG_G_W, `FPG_H_W};
  int          err_total = 0;
  int          checks = 0;
  int          cyc = 0;

  fpg_gpio dut_u (.mclk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .e_pin_i, .e_pin_o, .e_pin_oe_o,
    .f_pin_i, .f_pin_o, .f_pin_oe_o, .g_pin_i, .g_pin_o, .g_pin_oe_o, .h_pin_i, .h_pin_o,
    .h_pin_oe_o, .timer_edge_level_select_i, .timer_chan_out_i, .timer_chan_oe_i,
    .keypad_irq_enable_bits_i);
  fpg_pin_model #(.W(8)) e_m (.drv_i(e_pin_o), .oe_i(e_pin_oe_o), .board_i(ext[0]), .lvl_o(e_pin_i));
  fpg_pin_model #(.W(7)) f_m (.drv_i(f_pin_o), .oe_i(f_pin_oe_o), .board_i(ext[1][6:0]), .lvl_o(f_pin_i));
  fpg_pin_model #(.W(3)) g_m (.drv_i(g_pin_o), .oe_i(g_pin_oe_o), .board_i(ext[2][2:0]), .lvl_o(g_pin_i));
  fpg_pin_model #(.W(2)) h_m (.drv_i(h_pin_o), .oe_i(h_pin_oe_o), .board_i(ext[3][1:0]), .lvl_o(h_pin_i));

  // Gather the per-port outputs so one scenario task serves all four ports.
  always_comb begin
    oe_w[0]  = e_pin_oe_o;
    oe_w[1]  = {1'b0, f_pin_oe_o};
    oe_w[2]  = {5'h00, g_pin_oe_o};
    oe_w[3]  = {6'h00, h_pin_oe_o};
    drv_w[0] = e_pin_o;
    drv_w[1] = {1'b0, f_pin_o};
    drv_w[2] = {5'h00, g_pin_o};
    drv_w[3] = {6'h00, h_pin_o};
  end

  // Free-running bus clock of 100 ns.
  always #50 mclk_i = ~mclk_i;

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // Holds the request until waitrequest is sampled low; the timeout alone ends a stuck wait.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge mclk_i);
    avs_address_i   <= a;
    avs_write_i     <= w;
    avs_read_i      <= ~w;
    avs_writedata_i <= {24'h0, d};
    do @(posedge mclk_i);
    while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h0, exp}, "read data");
  endtask

  // Latch first, then direction, so the pin never shows a stale value when it turns on.
  task automatic run_port(input int p, input logic [7:0] lat, input logic [7:0] dir, input logic [7:0] brd);
    logic [7:0] m;
    m = 8'hff >> (8 - pw[p]);
    @(posedge mclk_i);
    ext[p] <= brd;
    wr(`FPG_E_LATCH_IDX + 8'(p), lat);
    wr(`FPG_E_DIR_IDX + 8'(p), dir);
    repeat (6) @(posedge mclk_i);
    chk(oe_w[p], dir & m, "output enable");
    chk(drv_w[p] & dir, lat & dir & m, "pin drive");
    rdc(`FPG_E_DIR_IDX + 8'(p), dir & m);
    rdc(`FPG_E_LATCH_IDX + 8'(p), ((lat & dir) | (brd & ~dir)) & m);
    wr(`FPG_E_LATCH_IDX + 8'(p), ~lat);
    rdc(`FPG_E_LATCH_IDX + 8'(p), ((~lat & dir) | (brd & ~dir)) & m);
  endtask

  task automatic timer_own();
    wr(`FPG_F_DIR_IDX, 8'h7f);
    @(posedge mclk_i);
    timer_edge_level_select_i <= 6'h21;
    repeat (3) @(posedge mclk_i);
    chk(f_pin_oe_o, 7'h5e, "timer pins 0 and 5");
    timer_edge_level_select_i <= 6'h1e;
    repeat (3) @(posedge mclk_i);
    chk(f_pin_oe_o, 7'h61, "timer pins 1 to 4");
    timer_chan_oe_i  <= 6'h3f;
    timer_chan_out_i <= 6'h2a;
    repeat (3) @(posedge mclk_i);
    chk(f_pin_o[5:0] & 6'h1e, 6'h0a, "timer drive");
    rdc(`FPG_F_LATCH_IDX, 8'h2a);
    timer_edge_level_select_i <= 6'h00;
    timer_chan_oe_i <= 6'h00;
  endtask

  task automatic keypad_own();
    wr(`FPG_G_DIR_IDX, 8'h07);
    wr(`FPG_H_DIR_IDX, 8'h03);
    keypad_irq_enable_bits_i <= 5'h15;
    repeat (3) @(posedge mclk_i);
    chk(g_pin_oe_o, 3'h2, "keypad port g");
    chk(h_pin_oe_o, 2'h1, "keypad port h");
    keypad_irq_enable_bits_i <= 5'h00;
  endtask

  // A second reset in mid-run must clear directions yet keep the port F latch.
  task automatic reset_keep();
    wr(`FPG_F_LATCH_IDX, 8'h2b);
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    chk({e_pin_oe_o, f_pin_oe_o, g_pin_oe_o, h_pin_oe_o}, 32'h0, "enables in reset");
    rst_i <= 1'b0;
    for (int i = 0; i < 4; i++) rdc(`FPG_E_DIR_IDX + 8'(i), 8'h00);
    wr(`FPG_F_DIR_IDX, 8'h7f);
    rdc(`FPG_F_LATCH_IDX, 8'h2b);
  endtask

  // Cycle ceiling well above the roughly 160 cycles the scenarios need.
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end

  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    run_port(0, 8'ha5, 8'hf0, 8'h3c);
    run_port(1, 8'h55, 8'h0f, 8'h6a);
    run_port(2, 8'h06, 8'h05, 8'h03);
    run_port(3, 8'h01, 8'h02, 8'h03);
    timer_own();
    keypad_own();
    rdc(8'h20, 8'h00);
    reset_keep();
    end_sim();
  end
endmodule
